// ==== testbench/wscs_checker.sv ====
// Purpose: Pin-level assertions for the configuration slave.
// Assumes: Sees only the ports of wscs_top.
// Notes: Bound into every wscs_top instance.
`timescale 1ns/1ps
module wscs_checker (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic scl_out,
   input wire logic sda_oe,
   input wire logic scl_oe,
   input wire logic [23:0] route_sel,
   input wire logic [7:0] clamp_sel,
   input wire logic [5:0] gain_zero_db,
   input wire logic [5:0] amp_idle_level,
   input wire logic write_strobe
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   a_pins_low_only: assert property (!sda_out && !scl_out && !scl_oe)
      else $error("Pin driven other than low.");
   a_ack_early: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("Ack began with clock high.");
   a_ack_holds: assert property ($rose(sda_oe) |-> sda_oe [*6])
      else $error("Ack slot cut short.");
   a_ack_high_held: assert property (sda_oe && scl_in |=> sda_oe)
      else $error("Ack dropped while clock high.");
   a_ack_drops_low: assert property ($fell(sda_oe) |-> !scl_in)
      else $error("Ack released while clock high.");
   a_strobe_pulse: assert property (write_strobe |=> !write_strobe)
      else $error("Write strobe too long.");
   a_cfg_by_strobe: assert property (
      !$stable({route_sel, clamp_sel, gain_zero_db}) |-> ##[0:3] write_strobe)
      else $error("Settings changed without a store.");
   a_reset_clears: assert property ($rose(rst_b) |->
      route_sel == 24'h0 && clamp_sel == 8'h0 && gain_zero_db == 6'h0
      && amp_idle_level == 6'h3F)
      else $error("Reset values wrong.");
   a_reset_quiet: assert property ($rose(rst_b) |-> !sda_oe [*3])
      else $error("Ack right after reset.");
endmodule : wscs_checker
bind wscs_top wscs_checker u_chk (.clk, .rst_b, .scl_in, .sda_out, .scl_out,
   .sda_oe, .scl_oe, .route_sel, .clamp_sel, .gain_zero_db,
   .amp_idle_level, .write_strobe);

// ==== testbench/wscs_link_master.sv ====
// Purpose: Behavioural two-wire bus master driving the slave.
// Assumes: Link clock period is eight system clocks, 200 ns.
// Notes: Lines are released high; the bench resolves the wire.
// Notes: Clock low phase is five clocks so the slave's ack settles first.
`timescale 1ns/1ps
module wscs_link_master (
   input wire logic clk,
   input wire logic sda_bus,
   output logic scl,
   output logic sda
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask : step
   task automatic start_cond();
      step(2);
      sda <= 1'b1;
      step(3);
      scl <= 1'b1;
      step(4);
      sda <= 1'b0;
      step(4);
      scl <= 1'b0;
   endtask : start_cond
   task automatic stop_cond();
      step(2);
      sda <= 1'b0;
      step(3);
      scl <= 1'b1;
      step(4);
      sda <= 1'b1;
      step(4);
   endtask : stop_cond
   task automatic xfer(input logic [7:0] b, output logic ack);
      for (int i = 8; i >= 0; i--) begin
         step(2);
         sda <= (i == 0) ? 1'b1 : b[i - 1];
         step(3);
         scl <= 1'b1;
         step(2);
         #1 ack = ~sda_bus;
         step(1);
         scl <= 1'b0;
      end
   endtask : xfer
endmodule : wscs_link_master

// ==== testbench/wscs_top_tb.sv ====
// Purpose: Self-checking bench for the configuration slave.
// Assumes: The master model drives the link lines.
// Notes: The bench tracks the expected settings itself.
`timescale 1ns/1ps
`include "wscs_defs.svh"
module wscs_top_tb;
   logic clk;
   logic rst_b = 1'b0;
   logic sda_out, sda_oe, scl_out, scl_oe, write_strobe, m_scl, m_sda;
   logic [23:0] route_sel, e_route;
   logic [7:0] clamp_sel, e_clamp;
   logic [5:0] gain_zero_db, amp_enable, amp_idle_level, e_gain;
   logic [15:0] tbl [6] = '{16'h0081, 16'h0130, 16'h029F, 16'h03A5,
      16'h04FF, 16'h0755};
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   wire scl_w = m_scl & ~(scl_oe & ~scl_out);
   wire sda_w = m_sda & ~(sda_oe & ~sda_out);
   wscs_top uut (.clk, .rst_b, .scl_in(scl_w), .sda_in(sda_w), .sda_out,
      .sda_oe, .scl_out, .scl_oe, .route_sel, .clamp_sel, .gain_zero_db,
      .amp_enable, .amp_idle_level, .write_strobe);
   wscs_link_master m (.clk, .sda_bus(sda_w), .scl(m_scl), .sda(m_sda));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude
   task automatic send(input logic [7:0] b, input logic ack);
      logic a;
      m.xfer(b, a);
      check(24'(a), 24'(ack));
   endtask : send
   task automatic addr(input logic ok);
      m.start_cond();
      send({`WSCS_DEV_ADDR ^ 7'(!ok), 1'b0}, ok);
   endtask : addr
   task automatic check_cfg();
      logic [5:0] en, idle;
      logic [3:0] s;
      repeat (8) @(posedge clk);
      for (int k = 0; k < 6; k++) begin
         s = e_route[4 * k +: 4];
         en[k] = s != `WSCS_SEL_OFF;
         idle[k] = s == `WSCS_SEL_OFF || s > `WSCS_SEL_MAX;
      end
      check(route_sel, e_route);
      check(24'(clamp_sel), 24'(e_clamp));
      check(24'(gain_zero_db), 24'(e_gain));
      check(24'(amp_enable), 24'(en));
      check(24'(amp_idle_level), 24'(idle));
   endtask : check_cfg
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      {e_route, e_clamp, e_gain} = '0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      check_cfg();
      foreach (tbl[i]) begin
         addr(1'b1);
         send(tbl[i][15:8], 1'b1);
         send(tbl[i][7:0], 1'b1);
         m.stop_cond();
         if (tbl[i][15:8] < `WSCS_REG_CLAMP) e_route[8 * i +: 8] = tbl[i][7:0];
         if (tbl[i][15:8] == `WSCS_REG_CLAMP) e_clamp = tbl[i][7:0];
         if (tbl[i][15:8] == `WSCS_REG_GAIN) e_gain = tbl[i][5:0];
         check_cfg();
      end
      addr(1'b1);
      send(`WSCS_REG_CLAMP, 1'b1);
      for (int i = 1; i < 4; i++) send(8'(8'h11 * i), 1'b1);
      m.stop_cond();
      e_clamp = 8'h33;
      check_cfg();
      addr(1'b0);
      send(`WSCS_REG_GAIN, 1'b0);
      m.start_cond();
      send({`WSCS_DEV_ADDR, 1'b1}, 1'b0);
      addr(1'b1);
      send(`WSCS_REG_ROUTE12, 1'b1);
      addr(1'b1);
      send(`WSCS_REG_GAIN, 1'b1);
      send(8'h2A, 1'b1);
      m.stop_cond();
      e_gain = 6'h2A;
      check_cfg();
      rst_b <= 1'b0;
      {e_route, e_clamp, e_gain} = '0;
      check_cfg();
      rst_b <= 1'b1;
      addr(1'b1);
      send(`WSCS_REG_ROUTE56, 1'b1);
      send(8'h12, 1'b1);
      m.stop_cond();
      e_route[23:16] = 8'h12;
      check_cfg();
      conclude();
   end
endmodule : wscs_top_tb

// ==== verilog/wscs_defs.svh ====
// Purpose: Named constants for the switch configuration serial slave.
// Assumes: Included by its bare name from the package and modules.
// Notes: Offsets are register indices carried in the pointer byte.
`ifndef WSCS_DEFS_SVH
`define WSCS_DEFS_SVH
`define WSCS_REG_ROUTE12 8'h00
`define WSCS_REG_ROUTE34 8'h01
`define WSCS_REG_ROUTE56 8'h02
`define WSCS_REG_CLAMP 8'h03
`define WSCS_REG_GAIN 8'h04
`define WSCS_ROUTE_RST 8'h00
`define WSCS_CLAMP_RST 8'h00
`define WSCS_GAIN_RST 6'h00
`define WSCS_SEL_OFF 4'h0
`define WSCS_SEL_MAX 4'h8
`define WSCS_BIT_LAST 3'h7
`define WSCS_BIT_FIRST 3'h0
`define WSCS_SCL_KHZ 100
`define WSCS_CLK_KHZ 40000
// Bus address of this slave; the value is arbitrary.
`define WSCS_DEV_ADDR 7'h43
`endif

// ==== verilog/wscs_line_if.sv ====
// Purpose: Carries conditioned link events from the front end to the core.
// Assumes: All signals are on clk.
// Notes: Events are one-cycle pulses.
`timescale 1ns/1ps
interface wscs_line_if;
   logic scl_rise;
   logic scl_fall;
   logic sda_bit;
   logic start_seen;
   logic stop_seen;
   modport front (output scl_rise, scl_fall, sda_bit, start_seen, stop_seen);
   modport core (input scl_rise, scl_fall, sda_bit, start_seen, stop_seen);
endinterface : wscs_line_if

// ==== verilog/wscs_line_sync.sv ====
// Purpose: Synchronises the link lines and finds edges and conditions.
// Assumes: Link lines are asynchronous to clk.
// Notes: First synchroniser stage feeds only the second stage.
`timescale 1ns/1ps
`include "wscs_defs.svh"
module wscs_line_sync
   import wscs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_in,
   wscs_line_if.front line
);
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic scl_old_reg;
   logic sda_old_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_old_reg <= 1'b1;
         sda_old_reg <= 1'b1;
      end else begin
         scl_old_reg <= scl_sync_reg[1];
         sda_old_reg <= sda_sync_reg[1];
      end
   end

   assign line.scl_rise = scl_sync_reg[1] & ~scl_old_reg;
   assign line.scl_fall = ~scl_sync_reg[1] & scl_old_reg;
   assign line.sda_bit = sda_sync_reg[1];
   // A data change while the clock is high is a condition, not a bit.
   assign line.start_seen = scl_sync_reg[1] & scl_old_reg &
      sda_old_reg & ~sda_sync_reg[1];
   assign line.stop_seen = scl_sync_reg[1] & scl_old_reg &
      ~sda_old_reg & sda_sync_reg[1];
endmodule : wscs_line_sync

// ==== verilog/wscs_pkg.sv ====
// Purpose: Types shared by the switch configuration slave modules.
// Assumes: Definitions header is available on the include path.
// Notes: Holds the link state enumeration only.
`include "wscs_defs.svh"
package wscs_pkg;
   typedef enum logic [2:0] {
      WSCS_IDLE,
      WSCS_ADDR,
      WSCS_ADDR_ACK,
      WSCS_PTR,
      WSCS_PTR_ACK,
      WSCS_DATA,
      WSCS_DATA_ACK,
      WSCS_IGNORE
   } wscs_state_t;
endpackage : wscs_pkg

// ==== verilog/wscs_top.sv ====
// Purpose: Write-only two-wire configuration slave for a video crosspoint.
// Assumes: clk at 40 MHz oversamples the link; master keeps its own rules.
// Notes: There is no read path; registers drive switch controls directly.
`timescale 1ns/1ps
`include "wscs_defs.svh"
module wscs_top
   import wscs_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = `WSCS_DEV_ADDR
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic scl_out,
   output logic scl_oe,
   output logic [23:0] route_sel,
   output logic [7:0] clamp_sel,
   output logic [5:0] gain_zero_db,
   output logic [5:0] amp_enable,
   output logic [5:0] amp_idle_level,
   output logic write_strobe
);
   // System clocks per nominal link clock period.
   localparam int SAMPLES_PER_BIT = `WSCS_CLK_KHZ / `WSCS_SCL_KHZ;

   wscs_line_if line ();
   wscs_state_t state_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] ptr_reg;
   logic [7:0] route_reg [0:2];
   logic [7:0] clamp_reg;
   logic [5:0] gain_reg;
   logic ack_drive_reg;
   logic strobe_reg;
   logic byte_done;
   logic [7:0] byte_val;
   logic addr_match;
   logic data_take;
   logic busy_reg;
   logic [4:0] reg_we;

   wscs_line_sync u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .line(line)
   );

   assign byte_done = line.scl_rise && (bit_cnt_reg == `WSCS_BIT_LAST);
   assign byte_val = {shift_reg[6:0], line.sda_bit};
   // Read direction or a foreign address is never acknowledged.
   assign addr_match = (byte_val == {DEV_ADDR, 1'b0});

   // Bits are shifted on clock rise, MSB first.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shift_reg <= 8'h00;
      end else if (line.scl_rise) begin
         shift_reg <= byte_val;
      end
   end

   // Bit counter restarts at every start and after each ack slot.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bit_cnt_reg <= `WSCS_BIT_FIRST;
      end else if (line.start_seen) begin
         bit_cnt_reg <= `WSCS_BIT_FIRST;
      end else if (line.scl_rise) begin
         unique case (state_reg)
            WSCS_ADDR, WSCS_PTR, WSCS_DATA: begin
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
            default: begin
               bit_cnt_reg <= `WSCS_BIT_FIRST;
            end
         endcase
      end
   end

   // Link state machine.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= WSCS_IDLE;
      end else if (line.stop_seen) begin
         state_reg <= WSCS_IDLE;
      end else if (line.start_seen) begin
         state_reg <= WSCS_ADDR;
      end else begin
         unique case (state_reg)
            WSCS_IDLE, WSCS_IGNORE: begin
               state_reg <= state_reg;
            end
            WSCS_ADDR: begin
               if (byte_done) begin
                  if (addr_match) begin
                     state_reg <= WSCS_ADDR_ACK;
                  end else begin
                     state_reg <= WSCS_IGNORE;
                  end
               end
            end
            WSCS_PTR: begin
               if (byte_done) begin
                  state_reg <= WSCS_PTR_ACK;
               end
            end
            WSCS_DATA: begin
               if (byte_done) begin
                  state_reg <= WSCS_DATA_ACK;
               end
            end
            WSCS_ADDR_ACK, WSCS_PTR_ACK, WSCS_DATA_ACK: begin
               // Leave the ack slot on the falling edge of the ninth clock.
               if (line.scl_fall && ack_drive_reg) begin
                  if (state_reg == WSCS_ADDR_ACK) begin
                     state_reg <= WSCS_PTR;
                  end else begin
                     state_reg <= WSCS_DATA;
                  end
               end
            end
         endcase
      end
   end

   // Ack drive starts at the fall after bit eight, ends at the ninth fall.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_drive_reg <= 1'b0;
      end else if (line.start_seen || line.stop_seen) begin
         ack_drive_reg <= 1'b0;
      end else if (line.scl_fall) begin
         unique case (state_reg)
            WSCS_ADDR_ACK, WSCS_PTR_ACK, WSCS_DATA_ACK: begin
               ack_drive_reg <= ~ack_drive_reg;
            end
            default: begin
               ack_drive_reg <= 1'b0;
            end
         endcase
      end
   end

   // Pointer loads from the first byte after the address.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ptr_reg <= 8'h00;
      end else if (state_reg == WSCS_PTR && byte_done) begin
         ptr_reg <= byte_val;
      end
   end

   // A data byte is taken at the clock rise of its eighth bit.
   assign data_take = (state_reg == WSCS_DATA) && byte_done;

   // Pointer decode; unknown pointers are acknowledged but store nothing.
   always_comb begin
      reg_we = 5'h00;
      if (data_take) begin
         unique case (ptr_reg)
            `WSCS_REG_ROUTE12: begin
               reg_we[0] = 1'b1;
            end
            `WSCS_REG_ROUTE34: begin
               reg_we[1] = 1'b1;
            end
            `WSCS_REG_ROUTE56: begin
               reg_we[2] = 1'b1;
            end
            `WSCS_REG_CLAMP: begin
               reg_we[3] = 1'b1;
            end
            `WSCS_REG_GAIN: begin
               reg_we[4] = 1'b1;
            end
            default: begin
               reg_we = 5'h00;
            end
         endcase
      end
   end

   // Routing registers, one per output pair.
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_route
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               route_reg[gi] <= `WSCS_ROUTE_RST;
            end else if (reg_we[gi]) begin
               route_reg[gi] <= byte_val;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clamp_reg <= `WSCS_CLAMP_RST;
      end else if (reg_we[3]) begin
         clamp_reg <= byte_val;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gain_reg <= `WSCS_GAIN_RST;
      end else if (reg_we[4]) begin
         gain_reg <= byte_val[5:0];
      end
   end

   // Store pulse for every data byte, whatever the pointer holds.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strobe_reg <= 1'b0;
      end else begin
         strobe_reg <= data_take;
      end
   end

   // Marks an open transaction from a start until its stop.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_reg <= 1'b0;
      end else if (line.stop_seen) begin
         busy_reg <= 1'b0;
      end else if (line.start_seen) begin
         busy_reg <= 1'b1;
      end
   end

   // The data pin is only ever pulled low, and only inside a transaction.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         sda_oe <= ack_drive_reg && busy_reg;
      end
   end

   // The clock pin is never driven; the master owns it.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_out <= 1'b0;
         scl_oe <= 1'b0;
      end else begin
         scl_out <= 1'b0;
         scl_oe <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         write_strobe <= 1'b0;
      end else begin
         write_strobe <= strobe_reg;
      end
   end

   // Per-output controls toward the analogue path.
   generate
      for (gi = 0; gi < 6; gi++) begin : g_out
         logic [3:0] sel;
         // Outputs one, three and five take the low nibble of their pair.
         assign sel = ((gi % 2) != 0) ? route_reg[gi / 2][7:4] :
            route_reg[gi / 2][3:0];

         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               route_sel[gi * 4 +: 4] <= `WSCS_SEL_OFF;
            end else begin
               route_sel[gi * 4 +: 4] <= sel;
            end
         end

         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               amp_enable[gi] <= 1'b0;
            end else begin
               amp_enable[gi] <= (sel != `WSCS_SEL_OFF);
            end
         end

         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               amp_idle_level[gi] <= 1'b1;
            end else begin
               amp_idle_level[gi] <= (sel == `WSCS_SEL_OFF) ||
                  (sel > `WSCS_SEL_MAX);
            end
         end

         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               gain_zero_db[gi] <= 1'b0;
            end else begin
               gain_zero_db[gi] <= gain_reg[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clamp_sel <= `WSCS_CLAMP_RST;
      end else begin
         clamp_sel <= clamp_reg;
      end
   end
endmodule : wscs_top
